// >>> tb/tb_top.sv
// Bench for the virtual output status map
`timescale 1ns/100ps

module tb_top;
  logic clk, nrst, go, rv, re, cv, ce, cg;
  logic [7:0] go_func, rq_f, rx, cx;
  logic [15:0] go_addr, rq_a, rd_, cd;
  logic [255:0] st, ft;
  int bad_count, cmp_count, k, i;
  int bits[4] = '{0, 15, 16, 63};
  int ext[4] = '{0, 1, 240, 255};
  logic [7:0] ef[8] = '{8'h04, 8'h03, 8'h02, 8'h01, 8'h02, 8'h02, 8'h05,
    8'h00};
  logic [15:0] ea[8] = '{16'h0008, 16'h03a4, 16'h0040, 16'h0040,
    16'h04e8, 16'h08d0, 16'h0000, 16'h0000};
  localparam logic [7:0] F_IN = vosm_pkg::FC_READ_INPUT;
  localparam logic [7:0] F_HR = vosm_pkg::FC_READ_HOLDING;
  localparam logic [7:0] F_DI = vosm_pkg::FC_READ_DISCRETE;
  localparam logic [7:0] F_CO = vosm_pkg::FC_READ_COILS;

  vosm_status_map u_dut (.clk(clk), .nrst(nrst), .vo_state(st),
    .vo_fault(ft), .req_valid(rv), .req_func(rq_f), .req_addr(rq_a),
    .rsp_valid(cv), .rsp_err(ce), .rsp_exc(rx), .rsp_data(rd_));
  vosm_client u_cli (.clk(clk), .go(go), .go_func(go_func),
    .go_addr(go_addr), .req_valid(rv), .req_func(rq_f), .req_addr(rq_a),
    .rsp_valid(cv), .rsp_err(ce), .rsp_exc(rx), .rsp_data(rd_),
    .got(cg), .got_err(re), .got_exc(cx), .got_data(cd));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk

  // One request, answer taken one cycle after the request edge
  task automatic rdw(input logic [7:0] f, input logic [15:0] a,
                     input logic [15:0] exp, input logic [7:0] exc);
    @(posedge clk);
    go <= 1'b1;
    go_func <= f;
    go_addr <= a;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    #1;
    chk({15'h0, cg}, 16'h0001);
    chk(cd, exp);
    chk({8'h0, cx}, {8'h0, exc});
    chk({15'h0, re}, {15'h0, exc != 8'h00});
    // The answer stands one cycle, then the port shows idle zeros
    @(posedge clk);
    #1;
    chk({15'h0, cg}, 16'h0000);
    chk(rd_, 16'h0000);
  endtask : rdw

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    #100000;
    bad_count++;
    tally_and_finish();
  end

  initial begin
    {nrst, go, go_func, go_addr, st, ft} = '0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    // Asymmetric nibbles expose bit-order and word-order slips
    for (k = 0; k < 16; k++) begin
      st[16*k+:16] <= {4'(k), 4'ha, ~4'(k), 4'h1};
      ft[16*k+:16] <= {4'h9, 4'(k), 4'h6, ~4'(k)};
    end
    @(posedge clk);
    for (k = 0; k < 4; k++) begin
      rdw(F_IN, 16'(k), st[16*k+:16], 8'h00);
      rdw(F_HR, 16'(k), st[16*k+:16], 8'h00);
      rdw(F_IN, 16'(k + 4), ft[16*k+:16], 8'h00);
      rdw(F_HR, 16'(k + 4), ft[16*k+:16], 8'h00);
    end
    $display("test basic words done");
    for (k = 0; k < 16; k++) begin
      rdw(F_IN, 16'h0384 + 16'(k), st[16*k+:16], 8'h00);
      rdw(F_HR, 16'h0394 + 16'(k), ft[16*k+:16], 8'h00);
    end
    rdw(F_HR, 16'h0393, st[255:240], 8'h00);
    rdw(F_IN, 16'h03a3, ft[255:240], 8'h00);
    $display("test extended words done");
    for (k = 0; k < 4; k++) begin
      i = bits[k];
      rdw(F_DI, 16'(i), {15'h0, st[i]}, 8'h00);
      rdw(F_CO, 16'(i), {15'h0, st[i]}, 8'h00);
      i = ext[k];
      rdw(F_DI, 16'h03e8 + 16'(i), {15'h0, st[i]}, 8'h00);
      rdw(F_DI, 16'h07d0 + 16'(i), {15'h0, ft[i]}, 8'h00);
    end
    $display("test bits done");
    for (k = 0; k < 8; k++)
      rdw(ef[k], ea[k], 16'h0000, k < 6 ? 8'h02 : 8'h01);
    $display("test refusals done");
    // Input then holding view of one word on back-to-back cycles
    @(posedge clk);
    go <= 1'b1;
    go_func <= F_IN;
    go_addr <= 16'h0385;
    @(posedge clk);
    go_func <= F_HR;
    @(posedge clk);
    go <= 1'b0;
    #1;
    chk(cd, st[31:16]);
    @(posedge clk);
    #1;
    chk({15'h0, cg}, 16'h0001);
    chk(cd, st[31:16]);
    $display("test back-to-back views done");
    // Reset in mid-run drops the answer to a request already taken
    @(posedge clk);
    go <= 1'b1;
    go_func <= F_IN;
    go_addr <= 16'h0000;
    @(posedge clk);
    go <= 1'b0;
    nrst <= 1'b0;
    @(posedge clk);
    #1;
    chk({15'h0, cg}, 16'h0000);
    chk(rd_, 16'h0000);
    @(posedge clk);
    nrst <= 1'b1;
    rdw(F_IN, 16'h0000, st[15:0], 8'h00);
    $display("test mid-run reset done");
    rdw(F_IN, 16'h0004, ft[15:0], 8'h00);
    rdw(F_DI, 16'h07d0, {15'h0, ft[0]}, 8'h00);
    @(posedge clk);
    st[15:0] <= 16'h8001;
    rdw(F_IN, 16'h0000, 16'h8001, 8'h00);
    $display("test reread and live update done");
    tally_and_finish();
  end
endmodule : tb_top

// >>> tb/vosm_client.sv
// Client model that issues single-item reads and keeps each answer
`timescale 1ns/100ps

module vosm_client (
  // Clock
  input wire logic clk,
  // Command from the bench
  input wire logic go,
  input wire logic [7:0] go_func,
  input wire logic [15:0] go_addr,
  // Request to the map
  output logic req_valid,
  output logic [7:0] req_func,
  output logic [15:0] req_addr,
  // Answer from the map
  input wire logic rsp_valid,
  input wire logic rsp_err,
  input wire logic [7:0] rsp_exc,
  input wire logic [15:0] rsp_data,
  // Last answer kept
  output logic got,
  output logic got_err,
  output logic [7:0] got_exc,
  output logic [15:0] got_data
);
  assign req_valid = go;
  assign req_func = go_func;
  // Idle address inverted so a stale value never looks like a request
  assign req_addr = go ? go_addr : ~go_addr;
  always_ff @(posedge clk) begin
    got <= rsp_valid;
    if (rsp_valid) begin
      got_err <= rsp_err;
      got_exc <= rsp_exc;
      got_data <= rsp_data;
    end
  end
endmodule : vosm_client

// >>> verilog/vosm_pkg.sv
// Constants for the virtual output status map
package vosm_pkg;

  // Request function codes
  localparam logic [7:0] FC_READ_COILS = 8'h01;
  localparam logic [7:0] FC_READ_DISCRETE = 8'h02;
  localparam logic [7:0] FC_READ_HOLDING = 8'h03;
  localparam logic [7:0] FC_READ_INPUT = 8'h04;

  // Exception codes returned on a refused request
  localparam logic [7:0] EXC_ILLEGAL_FUNC = 8'h01;
  localparam logic [7:0] EXC_ILLEGAL_ADDR = 8'h02;

  // Image sizes
  localparam int NUM_OUTPUTS = 256;
  localparam int WORD_BITS = 16;
  localparam int BASIC_OUTPUTS = 64;
  localparam int BASIC_WORDS = 4;
  localparam int EXT_WORDS = 16;

  // Zero-based word addresses, reference number minus one
  localparam logic [15:0] ADDR_OUT_WORDS = 16'h0000;
  localparam logic [15:0] ADDR_FAULT_WORDS = 16'h0004;
  localparam logic [15:0] ADDR_EXT_OUT_WORDS = 16'h0384;
  localparam logic [15:0] ADDR_EXT_FAULT_WORDS = 16'h0394;

  // Zero-based bit addresses for discrete inputs and coils
  localparam logic [15:0] ADDR_OUT_BITS = 16'h0000;
  localparam logic [15:0] ADDR_EXT_OUT_BITS = 16'h03e8;
  localparam logic [15:0] ADDR_EXT_FAULT_BITS = 16'h07d0;

  // Printed reference numbers of the basic words
  localparam logic [15:0] REF_OUTPUTS_1_TO_16 = 16'h7531;
  localparam logic [15:0] REF_OUTPUTS_17_TO_32 = 16'h7532;
  localparam logic [15:0] REF_OUTPUTS_33_TO_48 = 16'h7533;
  localparam logic [15:0] REF_OUTPUTS_49_TO_64 = 16'h7534;
  localparam logic [15:0] REF_FAULTS_1_TO_16 = 16'h7535;
  localparam logic [15:0] REF_FAULTS_17_TO_32 = 16'h7536;
  localparam logic [15:0] REF_FAULTS_33_TO_48 = 16'h7537;
  localparam logic [15:0] REF_FAULTS_49_TO_64 = 16'h7538;

  // Answer latency in clock cycles
  localparam int ANSWER_CYCLES = 1;

  typedef struct packed {
    logic rsp_valid;
    logic rsp_err;
    logic [7:0] rsp_exc;
    logic [15:0] rsp_data;
  } vosm_state_t;

endpackage : vosm_pkg

// >>> verilog/vosm_status_map.sv
// Read-only status image of the virtual outputs and their fault flags
//
// Contract
// [R1] First eight words hold outputs 1-64 and faults
// [R2] Function 04 returns these words as input registers
// [R3] Function 03 returns identical holding register values
// [R4] Lowest output in bit 0, highest in 15
// [R5] Outputs 1-64 map to words one to four
// [R6] Faults 1-64 map to words five to eight
// [R7] Outputs 1-64 also discrete inputs and coils
// [R8] All 256 outputs as contiguous discrete inputs
// [R9] All 256 outputs packed into sixteen words
// [R10] All 256 faults as contiguous discrete inputs
// [R11] All 256 faults packed into sixteen words
// [R12] Last extended word carries outputs 241-256
// [R13] Reads never alter any status or flag
`timescale 1ns/100ps

module vosm_status_map (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Status sources, same clock domain
  input wire logic [255:0] vo_state,
  input wire logic [255:0] vo_fault,
  // Read request from the protocol engine
  input wire logic req_valid,
  input wire logic [7:0] req_func,
  input wire logic [15:0] req_addr,
  // Answer
  output logic rsp_valid,
  output logic rsp_err,
  output logic [7:0] rsp_exc,
  output logic [15:0] rsp_data
);

  vosm_pkg::vosm_state_t s_q;
  vosm_pkg::vosm_state_t s_d;

  // Sixteen consecutive outputs, lowest numbered in bit 0
  function automatic logic [15:0] word_of(input logic [255:0] v,
                                          input logic [3:0] idx);
    word_of = v[idx*vosm_pkg::WORD_BITS +: vosm_pkg::WORD_BITS]; // see [R4]
  endfunction : word_of

  // True when a lies in [lo, lo+n)
  function automatic logic in_range(input logic [15:0] a,
                                    input logic [15:0] lo,
                                    input int n);
    in_range = (a >= lo) && ({16'h0000, a} < ({16'h0000, lo} + 32'(n)));
  endfunction : in_range

  logic [15:0] off_ow;
  logic [15:0] off_fw;
  logic [15:0] off_xow;
  logic [15:0] off_xfw;
  logic [15:0] off_xob;
  logic [15:0] off_xfb;

  assign off_ow = req_addr - vosm_pkg::ADDR_OUT_WORDS;
  assign off_fw = req_addr - vosm_pkg::ADDR_FAULT_WORDS;
  assign off_xow = req_addr - vosm_pkg::ADDR_EXT_OUT_WORDS;
  assign off_xfw = req_addr - vosm_pkg::ADDR_EXT_FAULT_WORDS;
  assign off_xob = req_addr - vosm_pkg::ADDR_EXT_OUT_BITS;
  assign off_xfb = req_addr - vosm_pkg::ADDR_EXT_FAULT_BITS;

  // Pure decode of live inputs: nothing is latched or cleared by a read
  always_comb begin // see [R13]
    s_d = s_q;
    s_d.rsp_valid = req_valid;
    s_d.rsp_err = 1'b0;
    s_d.rsp_exc = 8'h00;
    s_d.rsp_data = 16'h0000;
    if (req_valid) begin
      case (req_func)
        // Both register views share one decode so they cannot diverge
        vosm_pkg::FC_READ_INPUT,
        vosm_pkg::FC_READ_HOLDING: begin // see [R2] [R3]
          if (in_range(req_addr, vosm_pkg::ADDR_OUT_WORDS,
                       vosm_pkg::BASIC_WORDS)) begin
            s_d.rsp_data = word_of(vo_state, off_ow[3:0]); // see [R1] [R5]
          end else if (in_range(req_addr, vosm_pkg::ADDR_FAULT_WORDS,
                                vosm_pkg::BASIC_WORDS)) begin
            s_d.rsp_data = word_of(vo_fault, off_fw[3:0]); // see [R1] [R6]
          end else if (in_range(req_addr, vosm_pkg::ADDR_EXT_OUT_WORDS,
                                vosm_pkg::EXT_WORDS)) begin
            s_d.rsp_data = word_of(vo_state, off_xow[3:0]); // see [R9] [R12]
          end else if (in_range(req_addr, vosm_pkg::ADDR_EXT_FAULT_WORDS,
                                vosm_pkg::EXT_WORDS)) begin
            s_d.rsp_data = word_of(vo_fault, off_xfw[3:0]); // see [R11]
          end else begin
            s_d.rsp_err = 1'b1;
            s_d.rsp_exc = vosm_pkg::EXC_ILLEGAL_ADDR;
          end
        end
        vosm_pkg::FC_READ_DISCRETE: begin
          if (in_range(req_addr, vosm_pkg::ADDR_OUT_BITS,
                       vosm_pkg::BASIC_OUTPUTS)) begin
            s_d.rsp_data = {15'h0000, vo_state[req_addr[5:0]]}; // see [R7]
          end else if (in_range(req_addr, vosm_pkg::ADDR_EXT_OUT_BITS,
                                vosm_pkg::NUM_OUTPUTS)) begin
            s_d.rsp_data = {15'h0000, vo_state[off_xob[7:0]]}; // see [R8]
          end else if (in_range(req_addr, vosm_pkg::ADDR_EXT_FAULT_BITS,
                                vosm_pkg::NUM_OUTPUTS)) begin
            s_d.rsp_data = {15'h0000, vo_fault[off_xfb[7:0]]}; // see [R10]
          end else begin
            s_d.rsp_err = 1'b1;
            s_d.rsp_exc = vosm_pkg::EXC_ILLEGAL_ADDR;
          end
        end
        vosm_pkg::FC_READ_COILS: begin
          // Coils are a read-only echo of the state; no write path exists
          if (in_range(req_addr, vosm_pkg::ADDR_OUT_BITS,
                       vosm_pkg::BASIC_OUTPUTS)) begin
            s_d.rsp_data = {15'h0000, vo_state[req_addr[5:0]]}; // see [R7]
          end else begin
            s_d.rsp_err = 1'b1;
            s_d.rsp_exc = vosm_pkg::EXC_ILLEGAL_ADDR;
          end
        end
        default: begin
          s_d.rsp_err = 1'b1;
          s_d.rsp_exc = vosm_pkg::EXC_ILLEGAL_FUNC;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rsp_valid = s_q.rsp_valid;
  assign rsp_err = s_q.rsp_err;
  assign rsp_exc = s_q.rsp_exc;
  assign rsp_data = s_q.rsp_data;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  chk_answer_follows_req: assert property ( // see [R2]
    req_valid |=> rsp_valid ##1 (rsp_valid == $past(req_valid)))
    else $error("answer does not follow request by one cycle");

  chk_no_spurious_answer: assert property ( // see [R13]
    !req_valid |=> !rsp_valid && !rsp_err && rsp_data == 16'h0000)
    else $error("answer without request");

  chk_first_word_bits: assert property ( // see [R4] [R5]
    req_valid && req_func == 8'h04 && req_addr == 16'h0000
    |=> !rsp_err && rsp_data == $past(vo_state[15:0]))
    else $error("first output word wrong");

  chk_fourth_word_bits: assert property ( // see [R5]
    req_valid && req_func == 8'h04 && req_addr == 16'h0003
    |=> rsp_data == $past(vo_state[63:48]))
    else $error("outputs 49-64 word wrong");

  chk_holding_fault_word: assert property ( // see [R3] [R6]
    req_valid && req_func == 8'h03 && req_addr == 16'h0004
    |=> !rsp_err && rsp_data == $past(vo_fault[15:0]))
    else $error("holding view of faults 1-16 wrong");

  chk_eighth_word_fault: assert property ( // see [R1] [R6]
    req_valid && req_func == 8'h04 && req_addr == 16'h0007
    |=> rsp_data == $past(vo_fault[63:48]))
    else $error("faults 49-64 word wrong");

  chk_ext_last_word: assert property ( // see [R9] [R12]
    req_valid && req_func == 8'h03 && req_addr == 16'h0393
    |=> !rsp_err && rsp_data == $past(vo_state[255:240]))
    else $error("outputs 241-256 word wrong");

  chk_ext_fault_word: assert property ( // see [R11]
    req_valid && req_func == 8'h04 && req_addr == 16'h03a3
    |=> rsp_data == $past(vo_fault[255:240]))
    else $error("faults 241-256 word wrong");

  chk_ext_state_bit: assert property ( // see [R8]
    req_valid && req_func == 8'h02 && req_addr == 16'h03e8
    |=> rsp_data == {15'h0000, $past(vo_state[0])})
    else $error("extended discrete input one wrong");

  chk_ext_fault_bit: assert property ( // see [R10]
    req_valid && req_func == 8'h02 && req_addr == 16'h08cf
    |=> rsp_data == {15'h0000, $past(vo_fault[255])})
    else $error("extended fault input 256 wrong");

  chk_coil_last_bit: assert property ( // see [R7]
    req_valid && req_func == 8'h01 && req_addr == 16'h003f
    |=> !rsp_err && rsp_data == {15'h0000, $past(vo_state[63])})
    else $error("coil 64 wrong");

  chk_views_agree: assert property ( // see [R3] [R13]
    req_valid && req_func == 8'h04 && $stable(vo_state) && $stable(vo_fault)
    ##1 req_valid && req_func == 8'h03 && $stable(req_addr)
        && $stable(vo_state) && $stable(vo_fault)
    |=> rsp_data == $past(rsp_data) && rsp_err == $past(rsp_err))
    else $error("holding and input views differ");

  chk_gap_refused: assert property ( // see [R1]
    req_valid && req_func == 8'h04 && req_addr == 16'h0008
    |=> rsp_err && rsp_exc == 8'h02)
    else $error("unmapped word not refused");

  chk_bad_func: assert property ( // see [R2]
    req_valid && req_func == 8'h05
    |=> rsp_err && rsp_exc == 8'h01)
    else $error("unknown function not refused");

  chk_second_word_bits: assert property ( // see [R5]
    req_valid && req_func == 8'h04 && req_addr == 16'h0001
    |=> !rsp_err && rsp_data == $past(vo_state[31:16]))
    else $error("outputs 17-32 word wrong");

  chk_third_word_bits: assert property ( // see [R5]
    req_valid && req_func == 8'h04 && req_addr == 16'h0002
    |=> !rsp_err && rsp_data == $past(vo_state[47:32]))
    else $error("outputs 33-48 word wrong");

  chk_fault_word_two: assert property ( // see [R6]
    req_valid && req_func == 8'h04 && req_addr == 16'h0005
    |=> !rsp_err && rsp_data == $past(vo_fault[31:16]))
    else $error("faults 17-32 word wrong");

  // Extended ranges restart at output one, not after the basic words
  chk_ext_first_word: assert property ( // see [R9]
    req_valid && req_func == 8'h04 && req_addr == 16'h0384
    |=> !rsp_err && rsp_data == $past(vo_state[15:0]))
    else $error("extended outputs 1-16 word wrong");

  chk_ext_first_fault: assert property ( // see [R11]
    req_valid && req_func == 8'h03 && req_addr == 16'h0394
    |=> !rsp_err && rsp_data == $past(vo_fault[15:0]))
    else $error("extended faults 1-16 word wrong");

  chk_ext_word_gap: assert property ( // see [R11]
    req_valid && req_func == 8'h03 && req_addr == 16'h03a4
    |=> rsp_err && rsp_exc == 8'h02 && rsp_data == 16'h0000)
    else $error("word past extended faults not refused");

  chk_basic_state_bit: assert property ( // see [R7]
    req_valid && req_func == 8'h02 && req_addr == 16'h0000
    |=> !rsp_err && rsp_data == {15'h0000, $past(vo_state[0])})
    else $error("discrete input one wrong");

  chk_coil_first_bit: assert property ( // see [R7]
    req_valid && req_func == 8'h01 && req_addr == 16'h0000
    |=> !rsp_err && rsp_data == {15'h0000, $past(vo_state[0])})
    else $error("coil one wrong");

  chk_ext_last_bit: assert property ( // see [R8]
    req_valid && req_func == 8'h02 && req_addr == 16'h04e7
    |=> !rsp_err && rsp_data == {15'h0000, $past(vo_state[255])})
    else $error("extended discrete input 256 wrong");

  chk_ext_fault_first: assert property ( // see [R10]
    req_valid && req_func == 8'h02 && req_addr == 16'h07d0
    |=> !rsp_err && rsp_data == {15'h0000, $past(vo_fault[0])})
    else $error("extended fault input one wrong");

  chk_bit_gap_refused: assert property ( // see [R7]
    req_valid && req_func == 8'h02 && req_addr == 16'h0040
    |=> rsp_err && rsp_exc == 8'h02)
    else $error("discrete input 65 not refused");

  chk_coil_gap_refused: assert property ( // see [R7]
    req_valid && req_func == 8'h01 && req_addr == 16'h0040
    |=> rsp_err && rsp_exc == 8'h02)
    else $error("coil 65 not refused");

  chk_ext_bit_end: assert property ( // see [R8]
    req_valid && req_func == 8'h02 && req_addr == 16'h04e8
    |=> rsp_err && rsp_exc == 8'h02)
    else $error("input past extended outputs not refused");

  chk_fault_bit_end: assert property ( // see [R10]
    req_valid && req_func == 8'h02 && req_addr == 16'h08d0
    |=> rsp_err && rsp_exc == 8'h02)
    else $error("input past extended faults not refused");

  // Single-bit answers carry the bit in bit 0 only
  chk_bit_upper_zero: assert property ( // see [R7]
    req_valid && (req_func == 8'h01 || req_func == 8'h02)
    |=> rsp_data[15:1] == 15'h0000)
    else $error("bit answer has upper bits set");

  chk_exc_clear_ok: assert property ( // see [R2]
    rsp_valid && !rsp_err |-> rsp_exc == 8'h00)
    else $error("exception code on a good answer");

  chk_error_data_zero: assert property ( // see [R2]
    rsp_err |-> rsp_valid && rsp_data == 16'h0000)
    else $error("refused answer carries data");

  cov_input_read: cover property (
    req_valid && req_func == 8'h04 ##1 rsp_valid && !rsp_err);
  cov_holding_ext: cover property (
    req_valid && req_func == 8'h03 && req_addr == 16'h0393);
  cov_fault_bit: cover property (
    req_valid && req_func == 8'h02 && req_addr >= 16'h07d0);
  cov_refused: cover property (rsp_valid && rsp_err);
  cov_back_to_back: cover property (req_valid ##1 req_valid);

endmodule : vosm_status_map
